// File: bench/rcm_pin_model.sv
// Model of the external reset circuit that pulls the reset pin low.
`timescale 1ns/1ps
module rcm_pin_model (
   input  wire logic       clk_i,
   input  wire logic       start_i,
   input  wire logic [7:0] len_i,
   input  wire logic       dev_oe_n_i,
   output logic            pin_o
);
   logic [7:0] cnt_q = 8'h00;
   // The start request loads how many cycles the pin is held low.
   always_ff @(posedge clk_i)
   begin
      if (start_i)
         cnt_q <= len_i;
      else if (cnt_q != 8'h00)
         cnt_q <= cnt_q - 8'h01;
   end
   // The pin has a pull-up, so it reads high once nobody pulls it low.
   assign pin_o = !((cnt_q != 8'h00) || !dev_oe_n_i);
endmodule : rcm_pin_model

// File: bench/tb.sv
// Self-checking bench for the reset and clock mode control block.
`timescale 1ns/1ps
module tb;
   import rcm_pkg::*;
   logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, reset_pin_i, reset_pin_o, ps, s, cr;
   logic        wdt_reset_req_i, halt_release_i, fetch_valid_i, wb_ack_o, reset_pin_oe_n_o;
   logic        core_reset_o, trap_irq_o, use_slow_clk_o, fast_osc_en_o, slow_osc_en_o;
   logic        clear_dividers_o, irq_regs_clear_o, watchdog_en_o;
   logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, r;
   logic [3:0]  wb_sel_i;
   logic [15:0] fetch_addr_i, pc_load_o, a;
   logic [7:0]  pl;
   int          bad_count = 0, check_count = 0, cycles = 0, n, i;
   logic [15:0] tbl [5] = '{16'hC080, 16'hE060, 16'hE0A0, 16'hC040, 16'h8000};
   rcm_top dut (.*);
   rcm_pin_model pm (.clk_i(clk_i), .start_i(ps), .len_i(pl), .dev_oe_n_i(reset_pin_oe_n_o),
      .pin_o(reset_pin_i));
   always #10 clk_i = ~clk_i;
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : conclude
   // A hung wait counts as a mismatch and ends the run.
   always @(posedge clk_i)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         bad_count++;
         conclude();
      end
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e)
      begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [31:0] ad, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= ad;
      wb_dat_i <= d;
      do
         @(posedge clk_i);
      while (wb_ack_o !== 1'b1 && k++ < 50);
      r = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask : bus
   task automatic settle();
      int k;
      k = 0;
      while (core_reset_o !== 1'b0 && k++ < 200)
         @(posedge clk_i);
      repeat (2) @(posedge clk_i);
   endtask : settle
   task automatic pulse();
      int k;
      k = 0;
      n = 0;
      while (reset_pin_oe_n_o !== 1'b0 && k++ < 40)
         @(posedge clk_i);
      cr = core_reset_o;
      while (reset_pin_oe_n_o === 1'b0 && n < 100)
      begin
         @(posedge clk_i);
         n++;
      end
   endtask : pulse
   task automatic look(input int c, input int sel);
      s = 1'b0;
      repeat (c)
      begin
         @(posedge clk_i);
         s = s | ((sel == 0 ? trap_irq_o : sel == 1 ? core_reset_o : clear_dividers_o) === 1'b1);
      end
   endtask : look
   task automatic fetch(input logic [15:0] fa);
      @(posedge clk_i);
      fetch_valid_i <= 1'b1;
      fetch_addr_i <= fa;
      @(posedge clk_i);
      fetch_valid_i <= 1'b0;
   endtask : fetch
   function automatic logic trap_hit(input logic [15:0] ad, input logic ram);
      return ad <= RCM_SFR_END || (ad >= RCM_DBR_BASE && ad <= RCM_DBR_END)
         || (ram && ad <= RCM_RAM_END);
   endfunction : trap_hit
   function automatic logic faulty(input logic [7:0] o, input logic [7:0] v);
      logic xc, tc;
      xc = o[RCM_XEN_BIT] && !v[RCM_XEN_BIT];
      tc = o[RCM_XTEN_BIT] && !v[RCM_XTEN_BIT];
      return (xc && tc) || (xc && !v[RCM_SYSCK_BIT]) || (tc && v[RCM_SYSCK_BIT]);
   endfunction : faulty
   initial
   begin
      clk_i = 1'b0;
      rst_i = 1'b1;
      {wb_cyc_i, wb_stb_i, wb_we_i, wdt_reset_req_i, halt_release_i, fetch_valid_i, ps} = '0;
      {wb_adr_i, wb_dat_i, fetch_addr_i, pl} = '0;
      wb_sel_i = 4'hF;
      n = $urandom(36820);
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      settle();
      bus(1'b0, RCM_SYS_CTRL_OFS, '0);
      chk(r, {24'h00_0000, RCM_SYS_CTRL_RST});
      bus(1'b0, RCM_TRAP_CTRL_OFS, '0);
      chk(r, {30'h0, RCM_TRAP_CTRL_RST});
      bus(1'b0, 32'h0000_0040, '0);
      chk(r, 32'h0);
      chk({16'h0, pc_load_o}, {16'h0, RCM_RESET_VECTOR});
      chk({31'h0, watchdog_en_o}, 32'h1);
      $display("reset values done");
      for (i = 4; i >= 0; i--)
      begin
         bus(1'b1, RCM_TRAP_CTRL_OFS, 32'h0);
         bus(1'b1, RCM_SYS_CTRL_OFS, {24'h0, tbl[i][15:8]});
         bus(1'b1, RCM_SYS_CTRL_OFS, {24'h0, tbl[i][7:0]});
         pulse();
         chk(n, faulty(tbl[i][15:8], tbl[i][7:0]) ? RCM_MALF_CYCLES : 0);
         settle();
         bus(1'b0, RCM_TRAP_CTRL_OFS, '0);
         chk(r, {31'h0, faulty(tbl[i][15:8], tbl[i][7:0])});
      end
      $display("clock fault done");
      bus(1'b1, RCM_SYS_CTRL_OFS, 32'hE0);
      bus(1'b1, RCM_SYS_CTRL_OFS, 32'h60);
      bus(1'b0, RCM_STATUS_OFS, '0);
      chk({30'h0, r[1:0], fast_osc_en_o, use_slow_clk_o}, 32'h9);
      bus(1'b1, RCM_SYS_CTRL_OFS, 32'hE0);
      bus(1'b1, RCM_SYS_CTRL_OFS, 32'hC0);
      chk({31'h0, use_slow_clk_o}, 32'h1);
      for (n = 0; use_slow_clk_o !== 1'b0 && n < 30; n++)
         @(posedge clk_i);
      chk(n >= RCM_SYNC_CYCLES, 1);
      bus(1'b0, RCM_STATUS_OFS, '0);
      chk(r[1:0], 2'h1);
      $display("clock switch done");
      bus(1'b1, RCM_SYS_CTRL_OFS, 32'hE0);
      pl <= 8'($urandom_range(2, 9));
      ps <= 1'b1;
      @(posedge clk_i);
      ps <= 1'b0;
      look(30, 1);
      chk(s, 0);
      pl <= 8'($urandom_range(14, 34));
      ps <= 1'b1;
      @(posedge clk_i);
      ps <= 1'b0;
      look(60, 1);
      chk(s, 1);
      settle();
      bus(1'b0, RCM_STATUS_OFS, '0);
      chk({r[1:0], use_slow_clk_o, core_reset_o}, 4'h0);
      $display("external reset done");
      wdt_reset_req_i <= 1'b1;
      @(posedge clk_i);
      wdt_reset_req_i <= 1'b0;
      pulse();
      chk({cr, 31'(n)}, {1'b1, 31'(RCM_MALF_CYCLES)});
      settle();
      for (i = 0; i < 8; i++)
      begin
         bus(1'b1, RCM_TRAP_CTRL_OFS, {30'h0, i[0], 1'b0});
         case (i[2:1])
            2'd0: a = 16'($urandom_range(0, 'h3F));
            2'd1: a = 16'($urandom_range('h40, 'hF3F));
            2'd2: a = 16'($urandom_range('hF80, 'hFFF));
            default: a = 16'($urandom_range('h1000, 'hFFFD));
         endcase
         fetch(a);
         look(4, 0);
         chk(s, trap_hit(a, i[0]));
      end
      bus(1'b1, RCM_TRAP_CTRL_OFS, 32'h1);
      fetch(RCM_DBR_BASE);
      pulse();
      chk(n, RCM_MALF_CYCLES);
      settle();
      $display("address trap done");
      halt_release_i <= 1'b1;
      @(posedge clk_i);
      halt_release_i <= 1'b0;
      look(3, 2);
      chk(s, 1);
      $display("halt release done");
      conclude();
   end
endmodule : tb

// File: hdl/rcm_pkg.sv
// Package of constants for the reset and clock mode control block.
package rcm_pkg;
   // System control two register layout.
   localparam logic [31:0] RCM_SYS_CTRL_OFS  = 32'h0000_0000;
   localparam logic [31:0] RCM_TRAP_CTRL_OFS = 32'h0000_0004;
   localparam logic [31:0] RCM_STATUS_OFS    = 32'h0000_0008;
   localparam logic [31:0] RCM_TRAP_ADDR_OFS = 32'h0000_000C;
   localparam int          RCM_SYSCK_BIT     = 5;
   localparam int          RCM_XTEN_BIT      = 6;
   localparam int          RCM_XEN_BIT       = 7;
   // Reset values: fast oscillator on, slow off, fast clock selected.
   localparam logic [7:0]  RCM_SYS_CTRL_RST  = 8'h80;
   // Trap control: bit 0 trap action (1 = reset), bit 1 RAM area trapped.
   localparam int          RCM_TRAP_ACTION_SELECT_BIT     = 0;
   localparam int          RCM_TRAP_RAM_AREA_BIT      = 1;
   localparam logic [1:0]  RCM_TRAP_CTRL_RST = 2'h1;
   // Address regions for trap decoding.
   localparam logic [15:0] RCM_SFR_END       = 16'h003F;
   localparam logic [15:0] RCM_RAM_END       = 16'h0F3F;
   localparam logic [15:0] RCM_DBR_BASE      = 16'h0F80;
   localparam logic [15:0] RCM_DBR_END       = 16'h0FFF;
   localparam logic [15:0] RCM_RESET_VECTOR  = 16'hFFFE;
   // Timing.
   localparam int          RCM_CLK_MHZ       = 50;
   localparam int          RCM_MALF_CYCLES   = 24;
   localparam int          RCM_EXT_MIN_CYC   = 12;
   localparam int          RCM_SYNC_CYCLES   = 4;
   typedef enum logic [1:0] {RCM_MODE_FAST1, RCM_MODE_FAST2, RCM_MODE_SLOW} rcm_mode_t;
endpackage : rcm_pkg

// File: hdl/rcm_top.sv
// Reset generator and clock mode control with a Wishbone register port.
//
// The placing of the registers and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ps
// Notes on behaviour
// - Slow clock continues after select clears until clocks synchronize.
// - Reset pin low leaves slow mode; after reset single-clock fast mode.
// - Four reset sources; trap, watchdog and clock fault are malfunction resets.
// - A malfunction reset lasts 24 fast clocks and drives the pin low.
// - Malfunction stretcher is not initialized, so a power-up pulse may occur; here rst_i clears it, so none occurs.
// - Reset clears interrupt enables and latches and loads vector FFFE.
// - Reset clears prescaler and divider and leaves the watchdog enabled.
// - When the pin returns high execution starts at the fetched vector.
// - Fetch from special, buffer or flagged RAM area raises an address trap.
// - Trap action selects reset or interrupt; RAM trapped area is selectable.
// - Clearing an enable that the selected clock needs fires a clock reset.
// - Clock fault reset lasts 24 fast clocks with the pin driven low.
// - After any reset the trap action selects the reset request.
// - Leaving oscillator halt clears prescaler and divider.
module rcm_top
   import rcm_pkg::*;
#(
   parameter int MALF_CYCLES = rcm_pkg::RCM_MALF_CYCLES,
   parameter int EXT_MIN_CYC = rcm_pkg::RCM_EXT_MIN_CYC,
   parameter int SYNC_CYCLES = rcm_pkg::RCM_SYNC_CYCLES
)(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [31:0] wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic [3:0]  wb_sel_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        reset_pin_i,
   output logic             reset_pin_o,
   output logic             reset_pin_oe_n_o,
   input  wire logic        wdt_reset_req_i,
   input  wire logic        halt_release_i,
   input  wire logic        fetch_valid_i,
   input  wire logic [15:0] fetch_addr_i,
   output logic             core_reset_o,
   output logic             trap_irq_o,
   output logic             use_slow_clk_o,
   output logic             fast_osc_en_o,
   output logic             slow_osc_en_o,
   output logic             clear_dividers_o,
   output logic [15:0]      pc_load_o,
   output logic             irq_regs_clear_o,
   output logic             watchdog_en_o
);
   import rcm_pkg::*;

   localparam int CW = 8;
   localparam logic [CW-1:0] MALF_LEN = CW'(MALF_CYCLES);
   localparam logic [CW-1:0] EXT_LEN  = CW'(EXT_MIN_CYC);
   localparam logic [CW-1:0] SYNC_LEN = CW'(SYNC_CYCLES);

   logic          pin_s1_q, pin_s2_q;
   logic [CW-1:0] low_cnt_q, low_cnt_d;
   logic          ext_rst_q, ext_rst_d;
   logic [CW-1:0] malf_cnt_q, malf_cnt_d;
   logic          sysck_q, sysck_d, xten_q, xten_d, xen_q, xen_d;
   logic          trap_action_select_q, trap_action_select_d, trap_ram_area_q, trap_ram_area_d;
   logic          sel_slow_q, sel_slow_d;
   logic [CW-1:0] sync_cnt_q, sync_cnt_d;
   logic          ack_q, ack_d;
   logic [31:0]   dat_q, dat_d;
   logic          trap_irq_q, trap_irq_d;
   logic          pin_drv_q, pin_drv_d, core_rst_q, core_rst_d;
   logic          clr_div_q, clr_div_d;
   logic          wr_sys, in_trap_area, trap_hit, clk_fault, malf_req;
   logic          malf_active;
   rcm_mode_t     mode;

   // Without a power-on reset the stretcher may start mid-count.
   assign malf_active = (malf_cnt_q != '0);
   assign wr_sys = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q && wb_sel_i[0]
                   && (wb_adr_i == RCM_SYS_CTRL_OFS);
   assign in_trap_area = (fetch_addr_i <= RCM_SFR_END)
                        || (trap_ram_area_q && fetch_addr_i > RCM_SFR_END
                            && fetch_addr_i <= RCM_RAM_END)
                        || (fetch_addr_i >= RCM_DBR_BASE
                            && fetch_addr_i <= RCM_DBR_END);
   assign trap_hit  = fetch_valid_i && in_trap_area;
   assign clk_fault = wr_sys && (
        (xen_q && xten_q && !wb_dat_i[RCM_XEN_BIT] && !wb_dat_i[RCM_XTEN_BIT])
     || (xen_q && !wb_dat_i[RCM_XEN_BIT] && !sysck_q)
     || (xten_q && !wb_dat_i[RCM_XTEN_BIT] && sysck_q));
   assign malf_req = (trap_hit && trap_action_select_q) || wdt_reset_req_i || clk_fault;
   assign mode = sel_slow_q ? RCM_MODE_SLOW : (xten_q ? RCM_MODE_FAST2 : RCM_MODE_FAST1);

   always_comb
   begin
      low_cnt_d  = pin_s2_q ? '0 : (low_cnt_q == EXT_LEN ? low_cnt_q : low_cnt_q + 1'b1);
      ext_rst_d  = (low_cnt_d == EXT_LEN) || (ext_rst_q && !pin_s2_q);
      malf_cnt_d = malf_req ? MALF_LEN : (malf_active ? malf_cnt_q - 1'b1 : '0);
      sysck_d = sysck_q;
      xten_d  = xten_q;
      xen_d   = xen_q;
      trap_action_select_d = trap_action_select_q;
      trap_ram_area_d  = trap_ram_area_q;
      if (wr_sys && !clk_fault)
      begin
         sysck_d = wb_dat_i[RCM_SYSCK_BIT];
         xten_d  = wb_dat_i[RCM_XTEN_BIT];
         xen_d   = wb_dat_i[RCM_XEN_BIT];
      end
      if (wb_cyc_i && wb_stb_i && wb_we_i && !ack_q && wb_sel_i[0]
          && wb_adr_i == RCM_TRAP_CTRL_OFS)
      begin
         trap_action_select_d = wb_dat_i[RCM_TRAP_ACTION_SELECT_BIT];
         trap_ram_area_d  = wb_dat_i[RCM_TRAP_RAM_AREA_BIT];
      end
      // Clock select follows the bit at once when it is set, and only after the sync wait when it is cleared.
      sync_cnt_d = '0;
      sel_slow_d = sel_slow_q;
      if (sysck_q)
         sel_slow_d = 1'b1;
      else if (sel_slow_q)
      begin
         sync_cnt_d = sync_cnt_q + 1'b1;
         if (sync_cnt_q == SYNC_LEN)
         begin
            sel_slow_d = 1'b0;
            sync_cnt_d = '0;
         end
      end
      trap_irq_d = trap_hit && !trap_action_select_q;
      pin_drv_d  = (malf_cnt_d != '0);
      core_rst_d = pin_drv_d || ext_rst_d;
      clr_div_d  = core_rst_d || halt_release_i;
      ack_d = wb_cyc_i && wb_stb_i && !ack_q;
      dat_d = '0;
      unique case (wb_adr_i)
         RCM_SYS_CTRL_OFS:  dat_d = {24'h00_0000, xen_q, xten_q, sysck_q, 5'h00};
         RCM_TRAP_CTRL_OFS: dat_d = {30'h0000_0000, trap_ram_area_q, trap_action_select_q};
         RCM_STATUS_OFS:    dat_d = {28'h000_0000, ext_rst_q, malf_active, mode};
         default:           dat_d = '0;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      pin_s1_q   <= reset_pin_i;
      pin_s2_q   <= pin_s1_q;
      malf_cnt_q <= malf_cnt_d;
      if (rst_i)
      begin
         // The stretcher is only cleared by this reset, so no power-up pulse reaches the pin.
         malf_cnt_q <= '0;
         low_cnt_q  <= '0;
         ext_rst_q  <= 1'b0;
         sysck_q    <= RCM_SYS_CTRL_RST[RCM_SYSCK_BIT];
         xten_q     <= RCM_SYS_CTRL_RST[RCM_XTEN_BIT];
         xen_q      <= RCM_SYS_CTRL_RST[RCM_XEN_BIT];
         trap_action_select_q    <= RCM_TRAP_CTRL_RST[RCM_TRAP_ACTION_SELECT_BIT];
         trap_ram_area_q     <= RCM_TRAP_CTRL_RST[RCM_TRAP_RAM_AREA_BIT];
         sel_slow_q <= 1'b0;
         sync_cnt_q <= '0;
         ack_q      <= 1'b0;
         dat_q      <= '0;
         trap_irq_q <= 1'b0;
         pin_drv_q  <= 1'b0;
         core_rst_q <= 1'b1;
         clr_div_q  <= 1'b1;
      end
      else if (core_rst_q)
      begin
         // Internal reset returns to single-clock fast mode, trap set to reset.
         low_cnt_q  <= low_cnt_d;
         ext_rst_q  <= ext_rst_d;
         sysck_q    <= RCM_SYS_CTRL_RST[RCM_SYSCK_BIT];
         xten_q     <= RCM_SYS_CTRL_RST[RCM_XTEN_BIT];
         xen_q      <= RCM_SYS_CTRL_RST[RCM_XEN_BIT];
         trap_action_select_q    <= RCM_TRAP_CTRL_RST[RCM_TRAP_ACTION_SELECT_BIT];
         trap_ram_area_q     <= RCM_TRAP_CTRL_RST[RCM_TRAP_RAM_AREA_BIT];
         sel_slow_q <= 1'b0;
         sync_cnt_q <= '0;
         ack_q      <= ack_d;
         dat_q      <= dat_d;
         trap_irq_q <= 1'b0;
         pin_drv_q  <= pin_drv_d;
         core_rst_q <= core_rst_d;
         clr_div_q  <= clr_div_d;
      end
      else
      begin
         low_cnt_q  <= low_cnt_d;
         ext_rst_q  <= ext_rst_d;
         sysck_q    <= sysck_d;
         xten_q     <= xten_d;
         xen_q      <= xen_d;
         trap_action_select_q    <= trap_action_select_d;
         trap_ram_area_q     <= trap_ram_area_d;
         sel_slow_q <= sel_slow_d;
         sync_cnt_q <= sync_cnt_d;
         ack_q      <= ack_d;
         dat_q      <= dat_d;
         trap_irq_q <= trap_irq_d;
         pin_drv_q  <= pin_drv_d;
         core_rst_q <= core_rst_d;
         clr_div_q  <= clr_div_d;
      end
   end

   assign wb_ack_o         = ack_q;
   assign wb_dat_o         = dat_q;
   assign reset_pin_o      = 1'b0;
   assign reset_pin_oe_n_o = !pin_drv_q;
   assign core_reset_o     = core_rst_q;
   assign trap_irq_o       = trap_irq_q;
   assign use_slow_clk_o   = sel_slow_q;
   assign fast_osc_en_o    = xen_q;
   assign slow_osc_en_o    = xten_q;
   assign clear_dividers_o = clr_div_q;
   assign pc_load_o        = RCM_RESET_VECTOR;
   assign irq_regs_clear_o = core_rst_q;
   assign watchdog_en_o    = 1'b1;

   sequence malf_start_s;
      !rst_i && malf_req;
   endsequence
   sequence pin_low_s;
      !reset_pin_oe_n_o && core_reset_o;
   endsequence
   malf_pin_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
      malf_start_s |=> pin_low_s) else $error("malfunction did not drive pin");
   malf_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $fell(malf_active) |-> $past(malf_cnt_q) == 8'h01) else $error("bad count");
   clk_fault_a: assert property (@(posedge clk_i) disable iff (rst_i)
      clk_fault |=> !reset_pin_oe_n_o) else $error("clock fault missed");
   ext_short_a: assert property (@(posedge clk_i) disable iff (rst_i)
      pin_s2_q ##1 !pin_s2_q [*3] ##1 pin_s2_q |-> !ext_rst_q) else $error("short pulse");
   sync_wait_a: assert property (@(posedge clk_i) disable iff (rst_i || core_rst_q)
      $fell(sysck_q) |-> sel_slow_q [*3]) else $error("switched too soon");
   trap_irq_a: assert property (@(posedge clk_i) disable iff (rst_i || core_rst_q)
      trap_hit && !trap_action_select_q |=> trap_irq_o && reset_pin_oe_n_o) else $error("trap irq");
   trap_rst_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $fell(core_reset_o) |-> trap_action_select_q && !sel_slow_q) else $error("reset defaults");
   div_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
      halt_release_i |=> clear_dividers_o) else $error("divider not cleared");
endmodule : rcm_top
